// ==== core/flash_status_params.svh ====
// Constants of the flash status block
`ifndef FLASH_STATUS_PARAMS_SVH
`define FLASH_STATUS_PARAMS_SVH
// ****************************************
// Status word layout
// ****************************************
`define STAT_W 16
`define STAT_RESET 16'h0080
`define BIT_CRC_SUSP 8
`define BIT_READY 7
`define BIT_ERS_SUSP 6
`define BIT_ERS_FAIL 5
`define BIT_PGM_FAIL 4
`define BIT_BUF_ABORT 3
`define BIT_PGM_SUSP 2
`define BIT_PROT_ERR 1
`define BIT_SEC_RESULT 0
`define RESERVED_LSB 9
`define RESERVED_W 7
`define CRC_END_W 26
`define CRC_END_RESET 26'h3ffffff
`endif

// ==== core/flash_status_pkg.sv ====
// Types of the flash status block
package flash_status_pkg;
  // ****************************************
  // Types
  // ****************************************
  // Embedded operation activity
  typedef enum logic [4:0] {
    OP_IDLE = 5'b00001,
    OP_PROGRAM = 5'b00010,
    OP_SECTOR_ERASE = 5'b00100,
    OP_CHIP_ERASE = 5'b01000,
    OP_CRC = 5'b10000
  } op_state_t;
endpackage : flash_status_pkg

// ==== core/flash_status_register_logic.sv ====
// Status word, overlay read and fail flags of the flash status block
`timescale 1ns/1ps
`include "flash_status_params.svh"
module flash_status_register_logic (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Decoded command pulses
  input wire logic status_read_cmd_i,
  input wire logic clear_status_cmd_i,
  input wire logic soft_reset_cmd_i,
  input wire logic erase_suspend_cmd_i,
  input wire logic erase_resume_cmd_i,
  input wire logic program_suspend_cmd_i,
  input wire logic program_resume_cmd_i,
  input wire logic crc_suspend_cmd_i,
  input wire logic crc_resume_cmd_i,
  // Operation starts
  input wire logic program_start_i,
  input wire logic sector_erase_start_i,
  input wire logic chip_erase_start_i,
  input wire logic crc_start_i,
  input wire logic target_in_suspended_sector_i,
  input wire logic target_protected_i,
  // Operation completion
  input wire logic op_done_i,
  input wire logic op_fail_i,
  input wire logic buffer_abort_i,
  input wire logic sector_query_done_i,
  input wire logic sector_query_ok_i,
  // CRC end pointer load
  input wire logic crc_end_we_i,
  input wire logic [`CRC_END_W-1:0] crc_end_wdata_i,
  // Read access
  input wire logic read_access_i,
  input wire logic [15:0] array_rdata_i,
  // Outputs
  output logic [15:0] read_data_o,
  output logic overlay_active_o,
  output logic [`STAT_W-1:0] status_o,
  output logic [`CRC_END_W-1:0] crc_end_pointer_o,
  output logic op_accepted_o
);
  // ****************************************
  // Internal state
  // ****************************************
  flash_status_pkg::op_state_t op_q;
  flash_status_pkg::op_state_t op_d;
  logic [8:0] flags_q;
  logic [8:0] flags_d;
  logic overlay_q;
  logic overlay_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [`CRC_END_W-1:0] crc_end_q;
  logic [`CRC_END_W-1:0] crc_end_d;
  logic accepted_q;
  logic accepted_d;
  logic [`RESERVED_W-1:0] noise;
  logic [`STAT_W-1:0] status_word;
  logic ready;
  logic ers_susp;
  logic pgm_susp;
  logic illegal_pgm;
  logic illegal_ers;

  // ****************************************
  // Flag helpers
  // ****************************************
  // Result bits zeroed, state bits kept
  function automatic logic [8:0] results_cleared(input logic [8:0] f);
    logic [8:0] r;
    r = f;
    r[`BIT_ERS_FAIL] = 1'b0;
    r[`BIT_PGM_FAIL] = 1'b0;
    r[`BIT_BUF_ABORT] = 1'b0;
    r[`BIT_PROT_ERR] = 1'b0;
    r[`BIT_SEC_RESULT] = 1'b0;
    return r;
  endfunction : results_cleared

  // Program refused while program-suspended or into the erase-suspended sector
  function automatic logic program_refused(
    input logic start,
    input logic in_susp_sector,
    input logic e_susp,
    input logic p_susp
  );
    return start && ((e_susp && in_susp_sector) || p_susp);
  endfunction : program_refused

  // Erase of any kind refused while erase- or program-suspended
  function automatic logic erase_refused(
    input logic sector,
    input logic chip,
    input logic e_susp,
    input logic p_susp
  );
    return (sector || chip) && (e_susp || p_susp);
  endfunction : erase_refused

  // Status word from its parts
  function automatic logic [`STAT_W-1:0] pack_status(
    input logic [`RESERVED_W-1:0] rsv,
    input logic [8:0] f,
    input logic rdy
  );
    return {rsv, f[8], rdy, f[6:0]};
  endfunction : pack_status

  // ****************************************
  // Reserved bits
  // ****************************************
  // Undefined reserved bits
  reserved_noise u_noise (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .bits_o(noise)
  );

  // ****************************************
  // Status view
  // ****************************************
  // Ready and suspend views
  assign ready = (op_q == flash_status_pkg::OP_IDLE);
  assign ers_susp = flags_q[`BIT_ERS_SUSP];
  assign pgm_susp = flags_q[`BIT_PGM_SUSP];
  assign illegal_pgm = program_refused(program_start_i,
    target_in_suspended_sector_i, ers_susp, pgm_susp);
  assign illegal_ers = erase_refused(sector_erase_start_i,
    chip_erase_start_i, ers_susp, pgm_susp);

  // Assembled status word; reserved bits float
  assign status_word = pack_status(noise, flags_q, ready);

  // ****************************************
  // Operation and flags
  // ****************************************
  // Operation tracking and flag updates
  always_comb begin
    op_d = op_q;
    flags_d = flags_q;
    accepted_d = 1'b0;
    flags_d[`BIT_READY] = 1'b0;
    // Clear result bits; events below win over it
    if (clear_status_cmd_i || soft_reset_cmd_i) begin
      flags_d = results_cleared(flags_d);
    end
    unique case (op_q)
      flash_status_pkg::OP_IDLE: begin
        if (illegal_pgm) begin
          flags_d[`BIT_PGM_FAIL] = 1'b1;
        end else if (illegal_ers) begin
          flags_d[`BIT_ERS_FAIL] = 1'b1;
        end else if (program_start_i && target_protected_i) begin
          flags_d[`BIT_PGM_FAIL] = 1'b1;
          flags_d[`BIT_PROT_ERR] = 1'b1;
        end else if (sector_erase_start_i && target_protected_i) begin
          flags_d[`BIT_ERS_FAIL] = 1'b1;
          flags_d[`BIT_PROT_ERR] = 1'b1;
        end else if (program_start_i) begin
          op_d = flash_status_pkg::OP_PROGRAM;
          accepted_d = 1'b1;
        end else if (sector_erase_start_i) begin
          op_d = flash_status_pkg::OP_SECTOR_ERASE;
          accepted_d = 1'b1;
        end else if (chip_erase_start_i) begin
          op_d = flash_status_pkg::OP_CHIP_ERASE;
          accepted_d = 1'b1;
        end else if (crc_start_i || (crc_resume_cmd_i &&
                     flags_q[`BIT_CRC_SUSP])) begin
          op_d = flash_status_pkg::OP_CRC;
          flags_d[`BIT_CRC_SUSP] = 1'b0;
          accepted_d = 1'b1;
        end else if (erase_resume_cmd_i && ers_susp && !pgm_susp) begin
          op_d = flash_status_pkg::OP_SECTOR_ERASE;
          flags_d[`BIT_ERS_SUSP] = 1'b0;
        end else if (program_resume_cmd_i && pgm_susp) begin
          op_d = flash_status_pkg::OP_PROGRAM;
          flags_d[`BIT_PGM_SUSP] = 1'b0;
        end
        if (sector_query_done_i) begin
          flags_d[`BIT_SEC_RESULT] = sector_query_ok_i;
        end
      end
      flash_status_pkg::OP_PROGRAM: begin
        if (program_suspend_cmd_i || erase_suspend_cmd_i) begin
          op_d = flash_status_pkg::OP_IDLE;
          flags_d[`BIT_PGM_SUSP] = 1'b1;
        end else if (buffer_abort_i) begin
          op_d = flash_status_pkg::OP_IDLE;
          flags_d[`BIT_BUF_ABORT] = 1'b1;
          flags_d[`BIT_PGM_FAIL] = 1'b1;
        end else if (op_done_i) begin
          op_d = flash_status_pkg::OP_IDLE;
          flags_d[`BIT_PGM_FAIL] = op_fail_i;
        end
      end
      flash_status_pkg::OP_SECTOR_ERASE: begin
        if (erase_suspend_cmd_i) begin
          op_d = flash_status_pkg::OP_IDLE;
          flags_d[`BIT_ERS_SUSP] = 1'b1;
        end else if (op_done_i) begin
          op_d = flash_status_pkg::OP_IDLE;
          flags_d[`BIT_ERS_FAIL] = op_fail_i;
        end
      end
      flash_status_pkg::OP_CHIP_ERASE: begin
        // Suspend ignored; protected skips raise nothing
        if (op_done_i) begin
          op_d = flash_status_pkg::OP_IDLE;
          flags_d[`BIT_ERS_FAIL] = op_fail_i;
        end
      end
      flash_status_pkg::OP_CRC: begin
        if (crc_suspend_cmd_i) begin
          op_d = flash_status_pkg::OP_IDLE;
          flags_d[`BIT_CRC_SUSP] = 1'b1;
        end else if (op_done_i) begin
          op_d = flash_status_pkg::OP_IDLE;
        end
      end
      default: begin
        op_d = flash_status_pkg::OP_IDLE;
      end
    endcase
  end

  // ****************************************
  // Operation registers
  // ****************************************
  // Operation state registers; reset gives 0080 view
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op_q <= flash_status_pkg::OP_IDLE;
      flags_q <= 9'h000;
      accepted_q <= 1'b0;
    end else begin
      op_q <= op_d;
      flags_q <= flags_d;
      accepted_q <= accepted_d;
    end
  end

  // ****************************************
  // Overlay read
  // ****************************************
  // Overlay arm and single-read consume
  always_comb begin
    overlay_d = overlay_q;
    rdata_d = rdata_q;
    if (read_access_i) begin
      if (overlay_q) begin
        rdata_d = status_word;
      end else begin
        rdata_d = array_rdata_i;
      end
      overlay_d = 1'b0;
    end
    if (status_read_cmd_i) begin
      overlay_d = 1'b1;
    end
  end

  // ****************************************
  // Overlay registers
  // ****************************************
  // Overlay and read data registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overlay_q <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      overlay_q <= overlay_d;
      rdata_q <= rdata_d;
    end
  end

  // ****************************************
  // CRC end pointer
  // ****************************************
  // CRC end pointer next value
  always_comb begin
    crc_end_d = crc_end_q;
    if (crc_end_we_i && ready) begin
      crc_end_d = crc_end_wdata_i;
    end
  end

  // CRC end pointer register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_end_q <= `CRC_END_RESET;
    end else begin
      crc_end_q <= crc_end_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Outputs
  assign read_data_o = rdata_q;
  assign overlay_active_o = overlay_q;
  assign status_o = status_word;
  assign crc_end_pointer_o = crc_end_q;
  assign op_accepted_o = accepted_q;
endmodule : flash_status_register_logic

// ==== core/reserved_noise.sv ====
// Free-running pattern for reserved status bits
`timescale 1ns/1ps
`include "flash_status_params.svh"
module reserved_noise (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Pattern out
  output logic [`RESERVED_W-1:0] bits_o
);
  logic [`RESERVED_W-1:0] lfsr_q;
  logic [`RESERVED_W-1:0] lfsr_d;

  // ****************************************
  // Pattern generator
  // ****************************************
  // Seven-bit maximal LFSR step
  always_comb begin
    lfsr_d = {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
  end

  // Pattern register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lfsr_q <= 7'h01;
    end else begin
      lfsr_q <= lfsr_d;
    end
  end

  assign bits_o = lfsr_q;
endmodule : reserved_noise

// ==== dv/flash_status_chk.sv ====
// Port checks of the flash status block
`timescale 1ns/1ps
module flash_status_chk (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Inputs
  input wire logic status_read_cmd_i,
  input wire logic clear_status_cmd_i,
  input wire logic program_resume_cmd_i,
  input wire logic program_start_i,
  input wire logic sector_erase_start_i,
  input wire logic chip_erase_start_i,
  input wire logic op_done_i,
  input wire logic buffer_abort_i,
  input wire logic sector_query_done_i,
  input wire logic sector_query_ok_i,
  input wire logic read_access_i,
  input wire logic [15:0] array_rdata_i,
  // Outputs
  input wire logic [15:0] read_data_o,
  input wire logic overlay_active_o,
  input wire logic [15:0] status_o,
  input wire logic op_accepted_o
);
  // No result-flag event in this cycle
  wire quiet = !(op_done_i | buffer_abort_i | sector_query_done_i |
    program_start_i | sector_erase_start_i | chip_erase_start_i);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ****************************************
  // Assertions
  // ****************************************
  property p_arm; status_read_cmd_i |=> overlay_active_o; endproperty
  a_arm: assert property (p_arm) else $error("no overlay");
  property p_ovl; overlay_active_o && read_access_i |=>
    read_data_o[8:0] == $past(status_o[8:0]); endproperty
  a_ovl: assert property (p_ovl) else $error("overlay data");
  property p_exit; overlay_active_o && read_access_i &&
    !status_read_cmd_i |=> !overlay_active_o; endproperty
  a_exit: assert property (p_exit) else $error("overlay kept");
  property p_norm; !overlay_active_o && read_access_i |=>
    read_data_o == $past(array_rdata_i); endproperty
  a_norm: assert property (p_norm) else $error("array data");
  property p_busy; op_accepted_o |-> !status_o[7]; endproperty
  a_busy: assert property (p_busy) else $error("ready in op");
  property p_clr; clear_status_cmd_i && quiet |=>
    (status_o[5:0] & 6'h3b) == 6'h00; endproperty
  a_clr: assert property (p_clr) else $error("not cleared");
  property p_pres; program_resume_cmd_i && status_o[2] |=>
    !status_o[2]; endproperty
  a_pres: assert property (p_pres) else $error("still held");
  property p_qry; sector_query_done_i && status_o[7] |=>
    status_o[0] == $past(sector_query_ok_i); endproperty
  a_qry: assert property (p_qry) else $error("query bit");
  // Main scenarios
  c_ovl: cover property (overlay_active_o && read_access_i);
  c_clr: cover property (clear_status_cmd_i && quiet);
  c_pres: cover property (program_resume_cmd_i && status_o[2]);
endmodule : flash_status_chk
bind flash_status_register_logic flash_status_chk chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .status_read_cmd_i(status_read_cmd_i),
  .clear_status_cmd_i(clear_status_cmd_i),
  .program_resume_cmd_i(program_resume_cmd_i),
  .program_start_i(program_start_i),
  .sector_erase_start_i(sector_erase_start_i),
  .chip_erase_start_i(chip_erase_start_i), .op_done_i(op_done_i),
  .buffer_abort_i(buffer_abort_i),
  .sector_query_done_i(sector_query_done_i),
  .sector_query_ok_i(sector_query_ok_i), .read_access_i(read_access_i),
  .array_rdata_i(array_rdata_i), .read_data_o(read_data_o),
  .overlay_active_o(overlay_active_o), .status_o(status_o),
  .op_accepted_o(op_accepted_o)
);

// ==== dv/flash_status_register_logic_tb_top.sv ====
// Self-checking bench of the flash status block
`timescale 1ns/1ps
module flash_status_register_logic_tb_top;
  logic clk, rst_n, srd, rda, prot, insusp, fail, qok, acc, ovl;
  logic [15:0] cmd, ard, rdd, st, ex, v;
  logic [25:0] cwd, crcp;
  logic [31:0] seed;
  int miscompares, num_checks, tno, cyc;
  flash_status_register_logic uut (
    .ref_clk_i(clk), .rst_n_i(rst_n), .status_read_cmd_i(srd),
    .clear_status_cmd_i(cmd[0]), .soft_reset_cmd_i(cmd[1]),
    .erase_suspend_cmd_i(cmd[2]), .erase_resume_cmd_i(cmd[3]),
    .program_suspend_cmd_i(cmd[4]), .program_resume_cmd_i(cmd[5]),
    .crc_suspend_cmd_i(cmd[6]), .crc_resume_cmd_i(cmd[7]),
    .program_start_i(cmd[8]), .sector_erase_start_i(cmd[9]),
    .chip_erase_start_i(cmd[10]), .crc_start_i(cmd[11]),
    .target_in_suspended_sector_i(insusp), .target_protected_i(prot),
    .op_done_i(cmd[12]), .op_fail_i(fail), .buffer_abort_i(cmd[13]),
    .sector_query_done_i(cmd[14]), .sector_query_ok_i(qok),
    .crc_end_we_i(cmd[15]), .crc_end_wdata_i(cwd), .read_access_i(rda),
    .array_rdata_i(ard), .read_data_o(rdd), .overlay_active_o(ovl),
    .status_o(st), .crc_end_pointer_o(crcp), .op_accepted_o(acc));
  host_model host (.ref_clk_i(clk), .rst_n_i(rst_n), .read_data_i(rdd),
    .status_read_cmd_o(srd), .read_access_o(rda));
  // ****************************************
  // Clock, helpers and checks
  // ****************************************
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Expected word once result bits are cleared
  function automatic logic [15:0] after_clear(input logic [15:0] s);
    return s & 16'hffc4;
  endfunction : after_clear
  task complete_run();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One decoded pulse with its qualifying levels
  task pulse(input int k, input logic [3:0] lv);
    @(posedge clk);
    cmd <= 16'h0001 << k;
    {qok, prot, insusp, fail} <= lv;
    @(posedge clk);
    cmd <= 16'h0000;
  endtask : pulse
  task sc();
    host.rd_status(v);
    chk(v, ex);
  endtask : sc
  task test_done();
    tno++;
    $display("test %0d done", tno);
  endtask : test_done
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      complete_run();
    end
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    {cmd, ard, cwd, prot, insusp, fail, qok} = '0;
    rst_n = 1'b0;
    seed = 32'h2d85861f;
    ex = 16'h0080;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({7'h00, st[8:0]}, ex);
    chk(crcp[15:0], 16'hffff);
    chk({6'h00, crcp[25:16]}, 16'h03ff);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      @(posedge clk) ard <= seed[15:0];
      sc();
      chk({15'h0000, ovl}, 16'h0000);
      host.rd(v);
      chk(v, seed[15:0]);
    end
    test_done();
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      pulse(8 + i % 2, 4'h0);
      @(negedge clk);
      chk({15'h0000, st[7]}, 16'h0000);
      chk({15'h0000, acc}, 16'h0001);
      pulse(12, {3'b000, seed[0] | i[1]});
      ex[4 + i % 2] = seed[0] | i[1];
      sc();
    end
    for (int k = 0; k < 2; k++) begin
      pulse(8, 4'h4);
      ex = ex | 16'h0012;
      sc();
      pulse(k, 4'h0);
      ex = after_clear(ex);
      sc();
    end
    pulse(8, 4'h0);
    pulse(13, 4'h0);
    pulse(12, 4'h1);
    ex = ex | 16'h0018;
    sc();
    pulse(0, 4'h0);
    for (int i = 0; i < 2; i++) begin
      pulse(14, {i[0], 3'b000});
      ex = after_clear(ex) | {15'h0000, i[0]};
      sc();
    end
    test_done();
    pulse(9, 4'h0);
    pulse(2, 4'h0);
    host.poll(v);
    ex[6] = 1'b1;
    chk(v, ex);
    pulse(8, 4'h2);
    pulse(9, 4'h0);
    ex = ex | 16'h0030;
    sc();
    pulse(0, 4'h0);
    ex = after_clear(ex);
    sc();
    pulse(8, 4'h0);
    pulse(12, 4'h0);
    sc();
    pulse(3, 4'h0);
    pulse(12, 4'h0);
    ex[6] = 1'b0;
    sc();
    pulse(8, 4'h0);
    pulse(4, 4'h0);
    host.poll(v);
    ex[2] = 1'b1;
    chk(v, ex);
    pulse(8, 4'h0);
    pulse(9, 4'h0);
    ex = ex | 16'h0030;
    sc();
    pulse(5, 4'h0);
    pulse(12, 4'h0);
    ex[2] = 1'b0;
    ex[4] = 1'b0;
    sc();
    pulse(10, 4'h0);
    pulse(2, 4'h0);
    pulse(12, 4'h0);
    ex[5] = 1'b0;
    sc();
    pulse(11, 4'h0);
    pulse(6, 4'h0);
    host.poll(v);
    ex[8] = 1'b1;
    chk(v, ex);
    pulse(7, 4'h0);
    pulse(12, 4'h0);
    ex[8] = 1'b0;
    sc();
    test_done();
    seed = lfsr(seed);
    @(posedge clk) cwd <= seed[25:0];
    pulse(15, 4'h0);
    @(negedge clk);
    chk(crcp[15:0], seed[15:0]);
    chk({6'h00, crcp[25:16]}, {6'h00, seed[25:16]});
    pulse(8, 4'h1);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    ex = 16'h0080;
    sc();
    chk(crcp[15:0], 16'hffff);
    chk({6'h00, crcp[25:16]}, 16'h03ff);
    test_done();
    complete_run();
  end
endmodule : flash_status_register_logic_tb_top

// ==== dv/host_model.sv ====
// Host controller model issuing status and array reads
`timescale 1ns/1ps
module host_model (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Flash side
  input wire logic [15:0] read_data_i,
  output logic status_read_cmd_o,
  output logic read_access_o
);
  initial begin
    status_read_cmd_o = 1'b0;
    read_access_o = 1'b0;
  end
  // ****************************************
  // Host access tasks
  // ****************************************
  // One read access, data taken once it lands
  task rd(output logic [15:0] v);
    @(posedge ref_clk_i) read_access_o <= 1'b1;
    @(posedge ref_clk_i) read_access_o <= 1'b0;
    @(negedge ref_clk_i) v = read_data_i;
  endtask : rd
  // Status command, then exactly one read, reserved bits masked
  task rd_status(output logic [15:0] v);
    @(posedge ref_clk_i) status_read_cmd_o <= 1'b1;
    @(posedge ref_clk_i) status_read_cmd_o <= 1'b0;
    rd(v);
    v = v & 16'h01ff;
  endtask : rd_status
  // Poll status until ready, bounded
  task poll(output logic [15:0] v);
    for (int i = 0; i < 20; i++) begin
      rd_status(v);
      if (v[7] === 1'b1) break;
    end
  endtask : poll
endmodule : host_model
